// [excl_regs.svh]
// Purpose: constants of the exclusive-access monitor
// Assumes: 32-bit addresses, byte-addressed memory
// Notes:   definitions only
`ifndef EXCL_REGS_SVH
`define EXCL_REGS_SVH

`define EXCL_STATUS_OK    1'b0
`define EXCL_STATUS_FAIL  1'b1
`define EXCL_OFS_MAX      10'h3fc
`define EXCL_ADDR_RST     32'h0000_0000
`define EXCL_SIZE_RST     2'h2

`endif

// [excl_pkg.sv]
// Purpose: types of the exclusive-access monitor
// Assumes: nothing
// Notes:   included constants live in excl_regs.svh
package excl_pkg;
    // instruction issued to the monitor
    typedef enum logic [2:0] {
        OP_NONE       = 3'b000,
        OP_LOAD_EXCL  = 3'b001,
        OP_STORE_EXCL = 3'b010,
        OP_CLEAR_EXCL = 3'b011
    } op_e;
    // access size
    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_HALF = 2'b01,
        SZ_WORD = 2'b10
    } size_e;
    // request sequencer
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LOAD  = 2'b01,
        ST_STORE = 2'b10
    } state_e;
endpackage

// [addr_calc.sv]
// Purpose: effective address of an exclusive access
// Assumes: offset already checked by software to be a multiple of four
// Notes:   byte and half forms ignore the offset
`timescale 1ns/1ps
`default_nettype none
module addr_calc (
    // operands
    input  wire logic [31:0] base_in,
    input  wire logic [9:0]  ofs_in,
    input  wire logic        ofs_valid_in,
    input  wire logic [1:0]  size_in,
    // result
    output logic      [31:0] addr_out
);
    // base plus optional offset, word forms only
    always_comb begin
        if (ofs_valid_in && (size_in == excl_pkg::SZ_WORD)) begin
            addr_out = base_in + {22'h0, ofs_in};
        end else begin
            addr_out = base_in;
        end
    end
endmodule // addr_calc
`default_nettype wire

// [excl_monitor.sv]
// Purpose: exclusive load/store/clear monitor of a 32-bit core
// Assumes: one request at a time, held until done_out
// Notes:
`include "excl_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module excl_monitor (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    // instruction request
    input  wire logic        req_in,
    input  wire logic [2:0]  op_in,
    input  wire logic        cond_pass_in,
    input  wire logic [1:0]  size_in,
    input  wire logic [31:0] base_reg_in,
    input  wire logic [9:0]  ofs_in,
    input  wire logic        ofs_valid_in,
    input  wire logic [31:0] data_reg_in,
    input  wire logic [3:0]  flags_in,
    // instruction answer
    output logic             done_out,
    output logic [31:0]      load_data_out,
    output logic             status_out,
    output logic             status_we_out,
    output logic [3:0]       flags_out,
    // memory port
    output logic             mem_req_out,
    output logic             mem_we_out,
    output logic [31:0]      mem_addr_out,
    output logic [1:0]       mem_size_out,
    output logic [31:0]      mem_wdata_out,
    input  wire logic        mem_ack_in,
    input  wire logic [31:0] mem_rdata_in,
    // snoop of other bus masters
    input  wire logic        snoop_valid_in,
    input  wire logic [31:0] snoop_addr_in,
    // reservation state
    output logic             reserved_out
);
    // ------------------------------------------------------------
    // address and reservation
    // ------------------------------------------------------------
    logic [31:0] addr_w;
    logic        resv_r, resv_nxt;
    logic [31:0] resv_addr_r, resv_addr_nxt;
    logic [1:0]  resv_size_r, resv_size_nxt;
    excl_pkg::state_e st_r, st_nxt;
    logic        done_r, done_nxt;
    logic [31:0] ldata_r, ldata_nxt;
    logic        stat_r, stat_nxt;
    logic        stwe_r, stwe_nxt;
    logic [3:0]  flags_r, flags_nxt;
    logic        mreq_r, mreq_nxt;
    logic        mwe_r, mwe_nxt;
    logic [31:0] maddr_r, maddr_nxt;
    logic [1:0]  msize_r, msize_nxt;
    logic [31:0] mwdata_r, mwdata_nxt;
    logic        hit_w;
    logic        go_w;

    addr_calc u_addr (
        .base_in      (base_reg_in),
        .ofs_in       (ofs_in),
        .ofs_valid_in (ofs_valid_in),
        .size_in      (size_in),
        .addr_out     (addr_w)
    );

    // foreign access to the reserved word breaks the reservation
    assign hit_w = snoop_valid_in && (snoop_addr_in[31:2] == resv_addr_r[31:2]);
    // request is taken only when the sequencer is idle and done_r is low
    assign go_w  = req_in && (st_r == excl_pkg::ST_IDLE) && !done_r;

    // size-masked load data
    function automatic logic [31:0] mask_load(input logic [1:0] sz, input logic [31:0] d);
        logic [31:0] m;
        m = d;
        if (sz == excl_pkg::SZ_BYTE) begin
            m = {24'h0, d[7:0]};
        end else if (sz == excl_pkg::SZ_HALF) begin
            m = {16'h0, d[15:0]};
        end
        return m;
    endfunction

    // ------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt        = st_r;
        resv_nxt      = resv_r;
        resv_addr_nxt = resv_addr_r;
        resv_size_nxt = resv_size_r;
        done_nxt      = 1'b0;
        ldata_nxt     = ldata_r;
        stat_nxt      = stat_r;
        stwe_nxt      = 1'b0;
        flags_nxt     = flags_in;
        mreq_nxt      = mreq_r;
        mwe_nxt       = mwe_r;
        maddr_nxt     = maddr_r;
        msize_nxt     = msize_r;
        mwdata_nxt    = mwdata_r;
        if (hit_w) begin
            resv_nxt = 1'b0;
        end
        unique case (st_r)
            excl_pkg::ST_IDLE: begin
                if (go_w && !cond_pass_in) begin
                    done_nxt = 1'b1;
                end else if (go_w) begin
                    unique case (op_in)
                        excl_pkg::OP_LOAD_EXCL: begin
                            mreq_nxt      = 1'b1;
                            mwe_nxt       = 1'b0;
                            maddr_nxt     = addr_w;
                            msize_nxt     = size_in;
                            resv_nxt      = 1'b1;
                            resv_addr_nxt = addr_w;
                            resv_size_nxt = size_in;
                            st_nxt        = excl_pkg::ST_LOAD;
                        end
                        excl_pkg::OP_STORE_EXCL: begin
                            // unmatched address or size fails; either status would be allowed
                            if (resv_r && !hit_w && addr_w == resv_addr_r && size_in == resv_size_r) begin
                                mreq_nxt   = 1'b1;
                                mwe_nxt    = 1'b1;
                                maddr_nxt  = addr_w;
                                msize_nxt  = size_in;
                                mwdata_nxt = data_reg_in;
                                st_nxt     = excl_pkg::ST_STORE;
                            end else begin
                                stat_nxt = `EXCL_STATUS_FAIL;
                                stwe_nxt = 1'b1;
                                done_nxt = 1'b1;
                            end
                            resv_nxt = 1'b0;
                        end
                        excl_pkg::OP_CLEAR_EXCL: begin
                            resv_nxt = 1'b0;
                            done_nxt = 1'b1;
                        end
                        default: begin
                            done_nxt = 1'b1;
                        end
                    endcase
                end
            end
            excl_pkg::ST_LOAD: begin
                if (mem_ack_in) begin
                    mreq_nxt  = 1'b0;
                    ldata_nxt = mask_load(msize_r, mem_rdata_in);
                    done_nxt  = 1'b1;
                    st_nxt    = excl_pkg::ST_IDLE;
                end
            end
            excl_pkg::ST_STORE: begin
                if (mem_ack_in) begin
                    mreq_nxt = 1'b0;
                    stat_nxt = `EXCL_STATUS_OK;
                    stwe_nxt = 1'b1;
                    done_nxt = 1'b1;
                    st_nxt   = excl_pkg::ST_IDLE;
                end
            end
            default: begin
                st_nxt = excl_pkg::ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_r        <= excl_pkg::ST_IDLE;
            resv_r      <= 1'b0;
            resv_addr_r <= `EXCL_ADDR_RST;
            resv_size_r <= `EXCL_SIZE_RST;
            done_r      <= 1'b0;
            ldata_r     <= 32'h0;
            stat_r      <= `EXCL_STATUS_FAIL;
            stwe_r      <= 1'b0;
            flags_r     <= 4'h0;
            mreq_r      <= 1'b0;
            mwe_r       <= 1'b0;
            maddr_r     <= 32'h0;
            msize_r     <= 2'h0;
            mwdata_r    <= 32'h0;
        end else begin
            st_r        <= st_nxt;
            resv_r      <= resv_nxt;
            resv_addr_r <= resv_addr_nxt;
            resv_size_r <= resv_size_nxt;
            done_r      <= done_nxt;
            ldata_r     <= ldata_nxt;
            stat_r      <= stat_nxt;
            stwe_r      <= stwe_nxt;
            flags_r     <= flags_nxt;
            mreq_r      <= mreq_nxt;
            mwe_r       <= mwe_nxt;
            maddr_r     <= maddr_nxt;
            msize_r     <= msize_nxt;
            mwdata_r    <= mwdata_nxt;
        end
    end

    // outputs straight from flip-flops
    assign done_out      = done_r;
    assign load_data_out = ldata_r;
    assign status_out    = stat_r;
    assign status_we_out = stwe_r;
    assign flags_out     = flags_r;
    assign mem_req_out   = mreq_r;
    assign mem_we_out    = mwe_r;
    assign mem_addr_out  = maddr_r;
    assign mem_size_out  = msize_r;
    assign mem_wdata_out = mwdata_r;
    assign reserved_out  = resv_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence clr_seq;
        go_w && cond_pass_in && op_in == excl_pkg::OP_CLEAR_EXCL;
    endsequence
    sequence st_seq;
        go_w && cond_pass_in && op_in == excl_pkg::OP_STORE_EXCL;
    endsequence

    clear_drops_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        clr_seq |=> !resv_r && done_r) else $error("clear did not drop reservation");
    store_drops_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        st_seq |=> !resv_r) else $error("store kept reservation");
    fail_status_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        st_seq and !resv_r |=> status_we_out && status_out && !mem_req_out)
        else $error("failed store wrote memory or status 0");
    ok_status_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        st_r == excl_pkg::ST_STORE && mem_ack_in |=> status_we_out && !status_out)
        else $error("performed store did not return 0");
    snoop_breaks_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        hit_w && st_r == excl_pkg::ST_IDLE && !(go_w && op_in == excl_pkg::OP_LOAD_EXCL) |=> !resv_r)
        else $error("foreign access kept reservation");
    flags_keep_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        1'b1 |=> flags_out == $past(flags_in)) else $error("flags changed");
    load_record_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        go_w && cond_pass_in && op_in == excl_pkg::OP_LOAD_EXCL
        |=> reserved_out && resv_addr_r == mem_addr_out && resv_size_r == mem_size_out && mem_req_out && !mem_we_out)
        else $error("load not recorded");
    cond_skip_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        go_w && !cond_pass_in |=> done_r && !mem_req_out && !status_we_out && $stable(resv_r))
        else $error("skipped instruction acted");
    addr_word_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        go_w && cond_pass_in && op_in == excl_pkg::OP_LOAD_EXCL && size_in == excl_pkg::SZ_WORD && ofs_valid_in
        |=> mem_addr_out == $past(base_reg_in) + {22'h0, $past(ofs_in)})
        else $error("word address wrong");
endmodule // excl_monitor
`default_nettype wire

// [mem_partner.sv]
// Purpose: memory model on the far side of the monitor
// Assumes: word array of 16 entries, aligned accesses
// Notes:   ack after delay_in idle cycles, rdata scrambled outside ack
`timescale 1ns/1ps
`default_nettype none
module mem_partner (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    // answer speed
    input  wire logic [3:0]  delay_in,
    // memory port
    input  wire logic        mem_req_in,
    input  wire logic        mem_we_in,
    input  wire logic [31:0] mem_addr_in,
    input  wire logic [31:0] mem_wdata_in,
    output logic             mem_ack_out,
    output logic [31:0]      mem_rdata_out
);
    logic [31:0] mem_r [0:15];
    logic [3:0]  wait_r;
    int          wr_count;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    // known contents so the bench can predict reads
    initial begin
        for (int i = 0; i < 16; i++) mem_r[i] = 32'h8c4e_3100 | i;
    end
    // one-cycle ack, rdata valid only with it
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mem_ack_out   <= 1'b0;
            mem_rdata_out <= 32'h5a5a_5a5a;
            wait_r        <= 4'h0;
            wr_count      <= 0;
        end else if (mem_ack_out) begin
            mem_ack_out   <= 1'b0;
            mem_rdata_out <= ~mem_rdata_out;
        end else if (mem_req_in && wait_r < delay_in) begin
            wait_r        <= wait_r + 4'h1;
            mem_rdata_out <= ~mem_rdata_out;
        end else if (mem_req_in) begin
            mem_ack_out <= 1'b1;
            wait_r      <= 4'h0;
            if (mem_we_in) begin
                mem_r[mem_addr_in[5:2]] <= mem_wdata_in;
                wr_count <= wr_count + 1;
                wr_addr  <= mem_addr_in;
                wr_data  <= mem_wdata_in;
            end else mem_rdata_out <= mem_r[mem_addr_in[5:2]];
        end else mem_rdata_out <= ~mem_rdata_out;
    end
endmodule // mem_partner
`default_nettype wire

// [tb_exclusive_access_monitor.sv]
// Purpose: self-checking bench of the exclusive monitor
// Assumes: one request at a time, inputs driven at falling edge
// Notes:   memory answers from mem_partner
`include "excl_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_exclusive_access_monitor;
    logic clk_in, nrst_in, req_in, cond_pass_in, ofs_valid_in, done_out, status_out, status_we_out;
    logic mem_req_out, mem_we_out, mem_ack_in, snoop_valid_in, reserved_out;
    logic [2:0] op_in;
    logic [1:0] size_in, mem_size_out;
    logic [9:0] ofs_in;
    logic [3:0] flags_in, flags_out, delay;
    logic [31:0] base_reg_in, data_reg_in, load_data_out, mem_addr_out, mem_wdata_out, mem_rdata_in, snoop_addr_in;
    logic [31:0] got_addr, got_data;
    logic got_status, got_we, got_mwe;
    logic [1:0] got_size;
    int fail_count, comparisons, w0;
    excl_monitor u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .req_in(req_in), .op_in(op_in),
        .cond_pass_in(cond_pass_in), .size_in(size_in), .base_reg_in(base_reg_in), .ofs_in(ofs_in),
        .ofs_valid_in(ofs_valid_in), .data_reg_in(data_reg_in), .flags_in(flags_in), .done_out(done_out),
        .load_data_out(load_data_out), .status_out(status_out), .status_we_out(status_we_out),
        .flags_out(flags_out), .mem_req_out(mem_req_out), .mem_we_out(mem_we_out),
        .mem_addr_out(mem_addr_out), .mem_size_out(mem_size_out), .mem_wdata_out(mem_wdata_out),
        .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in), .snoop_valid_in(snoop_valid_in),
        .snoop_addr_in(snoop_addr_in), .reserved_out(reserved_out));
    mem_partner u_mem (.clk_in(clk_in), .nrst_in(nrst_in), .delay_in(delay), .mem_req_in(mem_req_out),
        .mem_we_in(mem_we_out), .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
        .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in));
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one instruction, held until done, outputs captured in the done cycle
    task automatic issue(input logic [2:0] op, input logic [1:0] sz, input logic [31:0] base,
                         input logic [9:0] ofs, input logic ofsv, input logic cond);
        int n;
        @(negedge clk_in);
        req_in = 1'b1; op_in = op; size_in = sz; base_reg_in = base;
        ofs_in = ofs; ofs_valid_in = ofsv; cond_pass_in = cond;
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
            if (mem_req_out === 1'b1) begin
                got_addr = mem_addr_out;
                got_size = mem_size_out;
                got_mwe  = mem_we_out;
            end
        end while (done_out !== 1'b1 && n < 50);
        chk(32'(n < 50), 32'h1);
        got_status = status_out; got_we = status_we_out; got_data = load_data_out;
        req_in = 1'b0;
    endtask
    task automatic end_sim;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_word;
        flags_in = 4'ha;
        issue(3'b001, 2'b10, 32'h0000_0010, 10'h008, 1'b1, 1'b1);
        chk(got_addr, 32'h0000_0018);
        chk(got_data, 32'h8c4e_3106);
        chk(32'({got_mwe, got_size}), 32'h2);
        chk(32'(reserved_out), 32'h1);
        chk(32'(flags_out), 32'ha);
        w0 = u_mem.wr_count; data_reg_in = 32'h1234_5678;
        issue(3'b010, 2'b10, 32'h0000_0010, 10'h008, 1'b1, 1'b1);
        chk(32'(got_status), 32'(`EXCL_STATUS_OK));
        chk(32'(got_we), 32'h1);
        chk(32'({got_mwe, got_size}), 32'h6);
        chk(u_mem.wr_addr, 32'h0000_0018);
        chk(u_mem.wr_data, 32'h1234_5678);
        chk(32'(reserved_out), 32'h0);
        issue(3'b010, 2'b10, 32'h0000_0010, 10'h008, 1'b1, 1'b1);
        chk(32'(got_status), 32'(`EXCL_STATUS_FAIL));
        chk(32'(u_mem.wr_count - w0), 32'h1);
        chk(32'(flags_out), 32'ha);
        $display("test word load/store done");
    endtask
    task automatic t_snoop;
        delay = 4'h3;
        issue(3'b001, 2'b00, 32'h0000_0020, 10'h008, 1'b0, 1'b1);
        chk(got_addr, 32'h0000_0020);
        chk(got_data, 32'h0000_0008);
        chk(32'({got_mwe, got_size}), 32'h0);
        @(negedge clk_in);
        snoop_valid_in = 1'b1; snoop_addr_in = 32'h0000_0020;
        @(negedge clk_in);
        snoop_valid_in = 1'b0; snoop_addr_in = 32'h0000_0100;
        w0 = u_mem.wr_count;
        issue(3'b010, 2'b00, 32'h0000_0020, 10'h000, 1'b0, 1'b1);
        chk(32'(got_status), 32'(`EXCL_STATUS_FAIL));
        chk(32'(u_mem.wr_count - w0), 32'h0);
        delay = 4'h0;
        $display("test snoop done");
    endtask
    task automatic t_clear;
        issue(3'b001, 2'b01, 32'h0000_0030, 10'h000, 1'b0, 1'b1);
        chk(got_data, 32'h0000_310c);
        chk(32'({got_mwe, got_size}), 32'h1);
        issue(3'b011, 2'b01, 32'h0000_0000, 10'h000, 1'b0, 1'b1);
        w0 = u_mem.wr_count;
        issue(3'b010, 2'b01, 32'h0000_0030, 10'h000, 1'b0, 1'b1);
        chk(32'(got_status), 32'(`EXCL_STATUS_FAIL));
        chk(32'(got_we), 32'h1);
        chk(32'(u_mem.wr_count - w0), 32'h0);
        $display("test clear done");
    endtask
    task automatic t_cond;
        issue(3'b001, 2'b10, 32'h0000_0040, 10'h3fc, 1'b0, 1'b1);
        chk(got_addr, 32'h0000_0040);
        issue(3'b011, 2'b10, 32'h0000_0000, 10'h000, 1'b0, 1'b0);
        w0 = u_mem.wr_count;
        issue(3'b010, 2'b10, 32'h0000_0040, 10'h000, 1'b0, 1'b0);
        chk(32'(u_mem.wr_count - w0), 32'h0);
        chk(32'(got_we), 32'h0);
        chk(32'(reserved_out), 32'h1);
        issue(3'b010, 2'b10, 32'h0000_0040, 10'h000, 1'b0, 1'b1);
        chk(32'(got_status), 32'(`EXCL_STATUS_OK));
        issue(3'b001, 2'b10, 32'h0000_0040, 10'h000, 1'b0, 1'b1);
        w0 = u_mem.wr_count;
        issue(3'b010, 2'b10, 32'h0000_0044, 10'h000, 1'b0, 1'b1);
        chk(32'(got_status), 32'(`EXCL_STATUS_FAIL));
        chk(32'(u_mem.wr_count - w0), 32'h0);
        chk(32'(reserved_out), 32'h0);
        $display("test condition done");
    endtask
    // ---------------------------------------------------------------
    // clock, reset, sequence, watchdog
    // ---------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    initial begin
        fail_count = 0; comparisons = 0; nrst_in = 1'b0; req_in = 1'b0; op_in = 3'b000;
        cond_pass_in = 1'b1; size_in = 2'b10; base_reg_in = 32'h0; ofs_in = 10'h0; ofs_valid_in = 1'b0;
        data_reg_in = 32'h0; flags_in = 4'h0; snoop_valid_in = 1'b0; snoop_addr_in = 32'h0000_0100;
        delay = 4'h0;
        repeat (12) @(negedge clk_in);
        nrst_in = 1'b1;
        t_word();
        t_snoop();
        t_clear();
        t_cond();
        end_sim();
    end
    initial begin
        #20000;
        fail_count++;
        end_sim();
    end
endmodule // tb_exclusive_access_monitor
`default_nettype wire
